// ===== logic/pdc_pkg.sv
/*
 * constants, register map and types of the positioning drive command logic.
 * assumes one 200 MHz clock, a synchronous active-high reset and APB access.
 */
// What this block does
// - inactive time stamp enables parameter-only control
// - control 0x10 plus target starts positioning
// - control word 0x00 cancels any run
// - new target retargets; reversal stops first
// - manual command slows run, then manual
// - release with stored target starts run
// - bit 6 disables the loop overrun
// - control 0x11 or 0x12 starts manual
// - 0x10 or 0x00 ends manual run
// - target during manual starts positioning
// - six-byte control 0x14 plus target starts
// - 0x04 with target, later 0x10 starts
// - eight-byte 0x14 with speed starts run
// - new process speed applies at once
// - eight-byte speed overrides parameter speeds
// - zero speed falls back to parameters
// - invalid speed blocks, aborts, flags error
// - speed clamped to per-direction maximum
// - accel 147, decel 148 on every run
// - deceleration eased near the destination
// - start torque for set time, then travel
`default_nettype none
package pdc_pkg;
   // apb geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // parameter indexes; byte address is four times the index
   localparam int IDX_CTRL = 110;
   localparam int IDX_TARGET = 112;
   localparam int IDX_SPD_POS = 142;
   localparam int IDX_MAX_CCW = 143;
   localparam int IDX_MAX_CW = 144;
   localparam int IDX_SPD_MAN = 145;
   localparam int IDX_ACC = 147;
   localparam int IDX_DEC = 148;
   localparam int IDX_TRQ_START = 152;
   localparam int IDX_TRQ_TRAVEL = 153;
   localparam int IDX_START_TIME = 160;
   localparam int IDX_STATUS = 200;
   // control word bit positions
   localparam int CB_MAN_CCW = 0;
   localparam int CB_MAN_CW = 1;
   localparam int CB_XFER = 2;
   localparam int CB_RELEASE = 4;
   localparam int CB_NO_LOOP = 6;
   localparam int CB_CLR_ERR = 14;
   // status word bit positions
   localparam int SB_RUN = 8;
   localparam int SB_MAN = 9;
   localparam int SB_ERR_TARGET = 12;
   // time stamp value that means inactive
   localparam logic [13:0] STAMP_OFF = 14'h3FFF;
   // valid speed window, 1/min
   localparam logic signed [15:0] SPD_LOW_OK = 16'sh000A;
   localparam logic signed [15:0] SPD_HIGH_OK = 16'sh0050;
   // parameter reset values
   localparam logic [15:0] RST_SPD_POS = 16'h0032;
   localparam logic [15:0] RST_MAX_DIR = 16'h0050;
   localparam logic [15:0] RST_SPD_MAN = 16'h0014;
   localparam logic [15:0] RST_ACC = 16'h0064;
   localparam logic [15:0] RST_DEC = 16'h0064;
   localparam logic [15:0] RST_TRQ_START = 16'h00C8;
   localparam logic [15:0] RST_TRQ_TRAVEL = 16'h0096;
   localparam logic [15:0] RST_START_TIME = 16'h0064;
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
   localparam int DWELL_NS = 1000;
   localparam logic [7:0] DWELL_CYC = 8'(DWELL_NS / CLK_PERIOD_NS);
   // near-destination window, steps
   localparam logic [31:0] NEAR_STEPS = 32'h00000100;
   // drive states
   typedef enum logic [2:0] {PDC_IDLE, PDC_POS, PDC_REV, PDC_SLOW, PDC_MAN} pdc_state_e;
   // process data layout in use
   typedef enum logic [1:0] {PDC_MODE_STAMP, PDC_MODE_6B, PDC_MODE_8B} pdc_mode_e;
endpackage
`default_nettype wire

// ===== logic/pdc_speed_sel.sv
/*
 * speed setpoint selection, validity check and direction clamp.
 * assumes all speeds signed 1/min; purely combinational.
 */
`default_nettype none
module pdc_speed_sel
   import pdc_pkg::*;
(
   input wire logic use_pd_in, // eight-byte layout active
   input wire logic signed [15:0] pd_speed_in, // speed from process data
   input wire logic manual_in, // manual kind of run
   input wire logic cw_in, // clockwise travel
   input wire logic signed [15:0] spd_pos_in, // positioning setpoint
   input wire logic signed [15:0] spd_man_in, // manual setpoint
   input wire logic signed [15:0] max_ccw_in, // ccw limit
   input wire logic signed [15:0] max_cw_in, // cw limit
   output logic [15:0] speed_out, // clamped speed
   output logic invalid_out // setpoint out of range
);
   // zero process speed falls back to the parameters
   wire pd_used = use_pd_in && (pd_speed_in != 16'sh0000);
   wire signed [15:0] par_sp = manual_in ? spd_man_in : spd_pos_in;
   wire signed [15:0] setp = pd_used ? pd_speed_in : par_sp;
   wire signed [15:0] limit = cw_in ? max_cw_in : max_ccw_in;
   // negative, 1..9 or above 80 is refused
   assign invalid_out = (setp < 16'sh0000) || ((setp > 16'sh0000) && (setp < SPD_LOW_OK))
      || (setp > SPD_HIGH_OK);
   // smaller of setpoint and direction limit
   assign speed_out = (setp < limit) ? setp : limit;
endmodule
`default_nettype wire

// ===== logic/pdc_drive_cmd.sv
/*
 * command logic of a positioning actuator: control word, target and speed
 * arrive either as process data frames or as parameter writes over APB.
 * assumes process data ports synchronous to core_clk_in, actual position
 * supplied by the motion controller, which consumes the run outputs.
 */
`default_nettype none
module pdc_drive_cmd
   import pdc_pkg::*;
#(
   parameter int MS_CYC_P = MS_CYC // cycles per millisecond
)
(
   input wire logic core_clk_in, // 200 MHz clock
   input wire logic rst_in, // synchronous reset, high
   input wire logic psel_in, // apb select
   input wire logic penable_in, // apb enable
   input wire logic pwrite_in, // apb direction
   input wire logic [pdc_pkg::ADDR_W-1:0] paddr_in, // apb byte address
   input wire logic [pdc_pkg::DATA_W-1:0] pwdata_in, // apb write data
   output logic [pdc_pkg::DATA_W-1:0] prdata_out, // apb read data
   output logic pready_out, // apb ready
   output logic pslverr_out, // apb error, unmapped
   input wire pdc_pkg::pdc_mode_e pd_mode_in, // process data layout
   input wire logic operate_in, // link in operate state
   input wire logic pd_valid_in, // new output frame, one cycle
   input wire logic [15:0] pd_ctrl_in, // frame control word
   input wire logic [31:0] pd_pos_in, // frame target position
   input wire logic [15:0] pd_speed_in, // frame target speed
   input wire logic [13:0] pd_stamp_in, // frame time stamp
   input wire logic [31:0] act_pos_in, // actual position
   output logic run_out, // drive moving
   output logic manual_out, // manual kind of run
   output logic dir_cw_out, // clockwise travel
   output logic loop_en_out, // loop overrun allowed
   output logic [31:0] target_out, // active target
   output logic [15:0] speed_out, // speed setpoint
   output logic [15:0] accel_out, // acceleration limit
   output logic [15:0] decel_out, // deceleration limit
   output logic [15:0] torque_out, // torque limit
   output logic err_target_out // incorrect target value
);
   localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'(IDX_CTRL * 4);
   localparam logic [ADDR_W-1:0] A_TARGET = ADDR_W'(IDX_TARGET * 4);
   localparam logic [ADDR_W-1:0] A_SPD_POS = ADDR_W'(IDX_SPD_POS * 4);
   localparam logic [ADDR_W-1:0] A_MAX_CCW = ADDR_W'(IDX_MAX_CCW * 4);
   localparam logic [ADDR_W-1:0] A_MAX_CW = ADDR_W'(IDX_MAX_CW * 4);
   localparam logic [ADDR_W-1:0] A_SPD_MAN = ADDR_W'(IDX_SPD_MAN * 4);
   localparam logic [ADDR_W-1:0] A_ACC = ADDR_W'(IDX_ACC * 4);
   localparam logic [ADDR_W-1:0] A_DEC = ADDR_W'(IDX_DEC * 4);
   localparam logic [ADDR_W-1:0] A_TRQ_START = ADDR_W'(IDX_TRQ_START * 4);
   localparam logic [ADDR_W-1:0] A_TRQ_TRAVEL = ADDR_W'(IDX_TRQ_TRAVEL * 4);
   localparam logic [ADDR_W-1:0] A_START_TIME = ADDR_W'(IDX_START_TIME * 4);
   localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(IDX_STATUS * 4);

   // stored words
   logic [15:0] ctrl_r; // effective control word
   logic [31:0] target_r; // active target
   logic [15:0] spd_pos_r, max_ccw_r, max_cw_r, spd_man_r; // speed parameters
   logic [15:0] acc_r, dec_r, trq_start_r, trq_travel_r, start_time_r; // other parameters
   logic [15:0] pd_spd_r; // last process speed
   logic pend_r; // target waits for release
   logic err_r; // incorrect target value, sticky
   pdc_state_e state_r, state_nxt; // drive state
   logic pend_nxt, err_set, start_travel; // fsm side outputs
   logic [7:0] dwell_r, dwell_nxt; // reverse/slowdown dwell
   logic [15:0] st_ms_r; // start torque ms left
   logic [31:0] tick_r; // ms prescaler
   logic pready_r, pslverr_r; // apb answer
   logic [DATA_W-1:0] prdata_r; // apb read data
   logic run_r, man_r, cw_r, loop_r; // output flops
   logic [15:0] speed_r, decel_r, torque_r; // output flops

   // apb decode; pready is raised for the access phase only
   wire setup_ph = psel_in && !penable_in;
   wire fire = psel_in && penable_in && pready_r;
   wire wr_fire = fire && pwrite_in;
   wire hit_par = (paddr_in == A_SPD_POS) || (paddr_in == A_MAX_CCW) || (paddr_in == A_MAX_CW)
      || (paddr_in == A_SPD_MAN) || (paddr_in == A_ACC) || (paddr_in == A_DEC)
      || (paddr_in == A_TRQ_START) || (paddr_in == A_TRQ_TRAVEL)
      || (paddr_in == A_START_TIME);
   wire hit = hit_par || (paddr_in == A_CTRL) || (paddr_in == A_TARGET)
      || (paddr_in == A_STATUS);

   // command sources
   wire acyc_ok = (pd_mode_in == PDC_MODE_STAMP) && (pd_stamp_in == STAMP_OFF);
   wire pd_ok = (pd_mode_in != PDC_MODE_STAMP) && operate_in && pd_valid_in;
   wire ctrl_ev = pd_ok || (acyc_ok && wr_fire && (paddr_in == A_CTRL));
   wire [15:0] ctrl_new = pd_ok ? pd_ctrl_in : pwdata_in[15:0];
   // frames carry a target only with the transfer bit
   wire tgt_ev = (pd_ok && pd_ctrl_in[CB_XFER])
      || (acyc_ok && wr_fire && (paddr_in == A_TARGET));
   wire [31:0] tgt_new = pd_ok ? pd_pos_in : pwdata_in;
   wire [15:0] ctrl_w = ctrl_ev ? ctrl_new : ctrl_r;
   wire [31:0] target_w = tgt_ev ? tgt_new : target_r;
   wire release_w = ctrl_w[CB_RELEASE];
   wire man_new = ctrl_ev && (ctrl_new[CB_MAN_CCW] || ctrl_new[CB_MAN_CW]);
   wire rel_rise = ctrl_ev && ctrl_new[CB_RELEASE] && !ctrl_r[CB_RELEASE];
   wire clr_err = ctrl_ev && ctrl_new[CB_CLR_ERR] && !ctrl_r[CB_CLR_ERR];
   wire cw_new = $signed(target_w) > $signed(act_pos_in);
   wire use_pd = (pd_mode_in == PDC_MODE_8B);
   wire [15:0] pd_spd_w = (pd_ok && use_pd) ? pd_speed_in : pd_spd_r;

   // positioning and manual setpoints, each checked and clamped
   wire [15:0] sp_pos, sp_man;
   wire inv_pos, inv_man;
   pdc_speed_sel u_sel_pos (
      .use_pd_in(use_pd),
      .pd_speed_in(pd_spd_w),
      .manual_in(1'b0),
      .cw_in(cw_new),
      .spd_pos_in(spd_pos_r),
      .spd_man_in(spd_man_r),
      .max_ccw_in(max_ccw_r),
      .max_cw_in(max_cw_r),
      .speed_out(sp_pos),
      .invalid_out(inv_pos)
   );
   pdc_speed_sel u_sel_man (
      .use_pd_in(use_pd),
      .pd_speed_in(pd_spd_w),
      .manual_in(1'b1),
      .cw_in(ctrl_w[CB_MAN_CW]),
      .spd_pos_in(spd_pos_r),
      .spd_man_in(spd_man_r),
      .max_ccw_in(max_ccw_r),
      .max_cw_in(max_cw_r),
      .speed_out(sp_man),
      .invalid_out(inv_man)
   );

   // remaining distance for the decel easing
   wire [31:0] diff = target_r - act_pos_in;
   wire [31:0] remain = diff[31] ? (32'h00000000 - diff) : diff;
   wire at_target = (act_pos_in == target_r);
   wire moving_nxt = (state_nxt != PDC_IDLE);
   wire man_kind_nxt = (state_nxt == PDC_MAN) || (state_nxt == PDC_SLOW);

   // drive state decisions, release first, then target, then manual
   always_comb
   begin
      state_nxt = state_r;
      pend_nxt = pend_r;
      dwell_nxt = (dwell_r != 8'h00) ? dwell_r - 8'h01 : 8'h00;
      err_set = 1'b0;
      start_travel = 1'b0;
      if (!release_w)
      begin
         // release withdrawn: stop, keep any target for later
         state_nxt = PDC_IDLE;
         if (tgt_ev)
            pend_nxt = 1'b1;
      end
      else if (tgt_ev || (rel_rise && pend_r))
      begin
         pend_nxt = 1'b0;
         if (inv_pos)
         begin
            state_nxt = PDC_IDLE;
            err_set = 1'b1;
         end
         else if ((state_r == PDC_POS) && (cw_new != cw_r))
         begin
            // reversal needs a stop before the new direction
            state_nxt = PDC_REV;
            dwell_nxt = DWELL_CYC;
         end
         else if (state_r == PDC_POS)
            state_nxt = PDC_POS;
         else if (state_r != PDC_REV)
         begin
            state_nxt = PDC_POS;
            start_travel = 1'b1;
         end
      end
      else if (man_new)
      begin
         if (inv_man)
         begin
            state_nxt = PDC_IDLE;
            err_set = 1'b1;
         end
         else if ((state_r == PDC_POS) || (state_r == PDC_REV))
         begin
            state_nxt = PDC_SLOW;
            dwell_nxt = DWELL_CYC;
         end
         else if (state_r == PDC_IDLE)
         begin
            state_nxt = PDC_MAN;
            start_travel = 1'b1;
         end
      end
      else
      begin
         case (state_r)
            PDC_POS:
            begin
               if (inv_pos)
               begin
                  state_nxt = PDC_IDLE;
                  err_set = 1'b1;
               end
               else if (at_target)
                  state_nxt = PDC_IDLE;
            end
            PDC_REV:
            begin
               if (dwell_r == 8'h00)
               begin
                  state_nxt = PDC_POS;
                  start_travel = 1'b1;
               end
            end
            PDC_SLOW, PDC_MAN:
            begin
               if (inv_man)
               begin
                  state_nxt = PDC_IDLE;
                  err_set = 1'b1;
               end
               else if (ctrl_ev && (state_r == PDC_MAN))
                  state_nxt = PDC_IDLE;
               else if ((state_r == PDC_SLOW) && (dwell_r == 8'h00))
                  state_nxt = PDC_MAN;
            end
            default:
               state_nxt = state_r;
         endcase
      end
   end

   // state, command words and flags
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         state_r <= PDC_IDLE;
         ctrl_r <= 16'h0000;
         target_r <= 32'h00000000;
         pd_spd_r <= 16'h0000;
         pend_r <= 1'b0;
         err_r <= 1'b0;
         dwell_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         ctrl_r <= ctrl_w;
         target_r <= target_w;
         pd_spd_r <= pd_spd_w;
         pend_r <= pend_nxt;
         // a new error wins over a clear in the same cycle
         err_r <= err_set || (err_r && !clr_err);
         dwell_r <= dwell_nxt;
      end
   end

   // parameter registers
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         spd_pos_r <= RST_SPD_POS;
         max_ccw_r <= RST_MAX_DIR;
         max_cw_r <= RST_MAX_DIR;
         spd_man_r <= RST_SPD_MAN;
         acc_r <= RST_ACC;
         dec_r <= RST_DEC;
         trq_start_r <= RST_TRQ_START;
         trq_travel_r <= RST_TRQ_TRAVEL;
         start_time_r <= RST_START_TIME;
      end
      else if (wr_fire)
      begin
         case (paddr_in)
            A_SPD_POS: spd_pos_r <= pwdata_in[15:0];
            A_MAX_CCW: max_ccw_r <= pwdata_in[15:0];
            A_MAX_CW: max_cw_r <= pwdata_in[15:0];
            A_SPD_MAN: spd_man_r <= pwdata_in[15:0];
            A_ACC: acc_r <= pwdata_in[15:0];
            A_DEC: dec_r <= pwdata_in[15:0];
            A_TRQ_START: trq_start_r <= pwdata_in[15:0];
            A_TRQ_TRAVEL: trq_travel_r <= pwdata_in[15:0];
            A_START_TIME: start_time_r <= pwdata_in[15:0];
            default: spd_pos_r <= spd_pos_r;
         endcase
      end
   end

   // start torque window, counted in whole milliseconds
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         st_ms_r <= 16'h0000;
         tick_r <= 32'h00000000;
      end
      else if (start_travel)
      begin
         st_ms_r <= start_time_r;
         tick_r <= 32'h00000000;
      end
      else if (st_ms_r != 16'h0000)
      begin
         if (tick_r == 32'(MS_CYC_P - 1))
         begin
            tick_r <= 32'h00000000;
            st_ms_r <= st_ms_r - 16'h0001;
         end
         else
            tick_r <= tick_r + 32'h00000001;
      end
   end

   // speed by kind of run; reverse dwell holds the drive still
   wire [15:0] speed_w = (state_nxt == PDC_POS) ? sp_pos
      : (man_kind_nxt ? sp_man : 16'h0000);
   // deceleration eased in three steps inside the near window
   wire [15:0] decel_w = (state_r != PDC_POS) ? dec_r
      : (remain < (NEAR_STEPS >> 4)) ? (dec_r >> 3)
      : (remain < (NEAR_STEPS >> 2)) ? (dec_r >> 2)
      : (remain < NEAR_STEPS) ? (dec_r >> 1) : dec_r;
   wire cw_w = man_kind_nxt ? ctrl_w[CB_MAN_CW] : cw_new;

   // drive outputs
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         run_r <= 1'b0;
         man_r <= 1'b0;
         cw_r <= 1'b0;
         loop_r <= 1'b1;
         speed_r <= 16'h0000;
         decel_r <= RST_DEC;
         torque_r <= RST_TRQ_TRAVEL;
      end
      else
      begin
         run_r <= moving_nxt;
         man_r <= man_kind_nxt;
         if (moving_nxt)
            cw_r <= cw_w;
         loop_r <= !ctrl_w[CB_NO_LOOP];
         speed_r <= speed_w;
         decel_r <= decel_w;
         torque_r <= (st_ms_r != 16'h0000) ? trq_start_r : trq_travel_r;
      end
   end

   // apb answer: ready in the access phase, data fetched at setup
   // flags widened before the shift so no bit is lost to a one-bit context
   wire [15:0] status_w = ({15'h0000, err_r} << SB_ERR_TARGET)
      | ({15'h0000, run_r} << SB_RUN) | ({15'h0000, man_r} << SB_MAN);
   wire [15:0] rd_w = (paddr_in == A_CTRL) ? ctrl_r
      : (paddr_in == A_SPD_POS) ? spd_pos_r : (paddr_in == A_MAX_CCW) ? max_ccw_r
      : (paddr_in == A_MAX_CW) ? max_cw_r : (paddr_in == A_SPD_MAN) ? spd_man_r
      : (paddr_in == A_ACC) ? acc_r : (paddr_in == A_DEC) ? dec_r
      : (paddr_in == A_TRQ_START) ? trq_start_r : (paddr_in == A_TRQ_TRAVEL) ? trq_travel_r
      : (paddr_in == A_START_TIME) ? start_time_r
      : (paddr_in == A_STATUS) ? status_w : 16'h0000;
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end
      else
      begin
         pready_r <= setup_ph;
         pslverr_r <= setup_ph && !hit;
         if (setup_ph)
            prdata_r <= (paddr_in == A_TARGET) ? target_r : {16'h0000, rd_w};
      end
   end

   assign prdata_out = prdata_r;
   assign pready_out = pready_r;
   assign pslverr_out = pslverr_r;
   assign run_out = run_r;
   assign manual_out = man_r;
   assign dir_cw_out = cw_r;
   assign loop_en_out = loop_r;
   assign target_out = target_r;
   assign speed_out = speed_r;
   assign accel_out = acc_r;
   assign decel_out = decel_r;
   assign torque_out = torque_r;
   assign err_target_out = err_r;

   // checks beside the logic
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   cancel_stops_a: assert property (ctrl_ev && !ctrl_new[CB_RELEASE] |=> !run_out)
      else $error("release withdrawn but drive still runs");
   target_starts_a: assert property (tgt_ev && release_w && !inv_pos |=> run_out && !manual_out
      && target_out == $past(tgt_new))
      else $error("target with release did not start positioning");
   pend_release_a: assert property (rel_rise && pend_r && !tgt_ev && !inv_pos
      && state_r == PDC_IDLE |=> run_out && !manual_out)
      else $error("release did not start stored target");
   no_loop_a: assert property (ctrl_ev && ctrl_new[CB_NO_LOOP] |=> !loop_en_out)
      else $error("loop still allowed with bit 6");
   manual_start_a: assert property (state_r == PDC_IDLE && man_new && release_w && !tgt_ev
      && !inv_man && !pend_r |=> run_out && manual_out ##1 torque_out == trq_start_r
      || start_time_r == 16'h0000)
      else $error("manual command did not start manual run");
   manual_end_a: assert property (state_r == PDC_MAN && ctrl_ev && !man_new && !tgt_ev
      |=> !run_out)
      else $error("manual run not ended");
   slow_down_a: assert property (state_r == PDC_POS && man_new && release_w && !tgt_ev
      && !inv_man |=> state_r == PDC_SLOW && manual_out && speed_out == $past(sp_man))
      else $error("positioning not slowed for manual");
   bad_speed_a: assert property (state_r == PDC_POS && inv_pos && release_w && !tgt_ev
      && !man_new |=> !run_out && err_target_out)
      else $error("invalid speed did not abort");
   reverse_stop_a: assert property (state_nxt == PDC_REV |=> speed_out == 16'h0000)
      else $error("drive not stopped during reversal");
   cover_pos_c: cover property (tgt_ev && release_w ##1 run_out ##[1:50] !run_out);
   cover_slow_c: cover property (state_r == PDC_SLOW ##[1:300] state_r == PDC_MAN);
   cover_rev_c: cover property (state_r == PDC_REV ##[1:300] state_r == PDC_POS);
endmodule
`default_nettype wire

// ===== test/pdc_master_model.sv
/*
 * far-side master model: sends one process output frame per request.
 * assumes requests at least two cycles apart and a synchronous reset.
 */
`default_nettype none
module pdc_master_model
   import pdc_pkg::*;
(
   input wire logic clk_in, // core clock
   input wire logic rst_in, // sync reset, high
   input wire logic send_in, // frame request
   input wire logic [15:0] ctrl_in, // control word
   input wire logic [31:0] pos_in, // target position
   input wire logic [15:0] spd_in, // target speed
   output logic operate_out, // link in operate
   output logic valid_out, // frame strobe
   output logic [15:0] ctrl_out, // frame control
   output logic [31:0] pos_out, // frame position
   output logic [15:0] spd_out, // frame speed
   output logic [13:0] stamp_out // time stamp
);
   timeunit 1ns;
   timeprecision 1ps;
   // stamp held off, so parameters alone steer in stamp layout
   assign stamp_out = STAMP_OFF;
   initial {operate_out, valid_out, ctrl_out, pos_out, spd_out} = '0;
   // operate before any frame; fields scrambled between frames so stale
   // values never look valid
   always @(posedge clk_in)
   begin
      operate_out <= !rst_in;
      valid_out <= send_in && !rst_in;
      ctrl_out <= send_in ? ctrl_in : ~ctrl_out;
      pos_out <= send_in ? pos_in : ~pos_out;
      spd_out <= send_in ? spd_in : ~spd_out;
   end
endmodule
`default_nettype wire

// ===== test/pdc_drive_cmd_bench.sv
/*
 * self-checking bench of the drive command logic.
 * assumes the master model feeds frames; actual position held at zero until the near-target step.
 */
`default_nettype none
module pdc_drive_cmd_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pdc_pkg::*;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, send = 0, op, rdy, serr, rerr;
   logic pv, run, man, cw, loop, err;
   logic [11:0] pa = '0;
   logic [31:0] pw = '0, prd, rd, pp, tgt, sp = '0, ap = '0;
   logic [15:0] pc, ps, spd, acc, dec, trq, sc = '0, ss = '0;
   logic [13:0] st;
   pdc_mode_e mode = PDC_MODE_STAMP;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   initial forever #2.5 clk = ~clk;
   // short millisecond keeps the start torque window at 1000 cycles
   pdc_drive_cmd #(.MS_CYC_P(10)) u_dut (.core_clk_in(clk), .rst_in(rst), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pw), .prdata_out(prd),
      .pready_out(rdy), .pslverr_out(serr), .pd_mode_in(mode), .operate_in(op),
      .pd_valid_in(pv), .pd_ctrl_in(pc), .pd_pos_in(pp), .pd_speed_in(ps), .pd_stamp_in(st),
      .act_pos_in(ap), .run_out(run), .manual_out(man), .dir_cw_out(cw),
      .loop_en_out(loop), .target_out(tgt), .speed_out(spd), .accel_out(acc),
      .decel_out(dec), .torque_out(trq), .err_target_out(err));
   pdc_master_model u_mst (.clk_in(clk), .rst_in(rst), .send_in(send), .ctrl_in(sc),
      .pos_in(sp), .spd_in(ss), .operate_out(op), .valid_out(pv), .ctrl_out(pc),
      .pos_out(pp), .spd_out(ps), .stamp_out(st));
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pw <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rd = prd;
      rerr = serr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // one frame; outputs settle one cycle after the take
   task automatic frame(input logic [15:0] c, input logic [31:0] p, input logic [15:0] s);
      @(posedge clk);
      sc <= c;
      sp <= p;
      ss <= s;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // hang guard, well above the planned length
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         stop_test();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("trq_rst", trq, 32'h00000096);
      apb(1'b0, 12'h238, 32'h0);
      chk("spd_pos_rst", rd, 32'h00000032);
      apb(1'b0, 12'h004, 32'h0);
      chk("unmapped", rerr, 32'h00000001);
      // stamp layout: parameter writes alone
      apb(1'b1, 12'h1C0, 32'h00001000);
      apb(1'b1, 12'h1B8, 32'h00000010);
      @(posedge clk);
      #1;
      chk("stamp_run", run, 32'h00000001);
      chk("stamp_tgt", tgt, 32'h00001000);
      apb(1'b1, 12'h1B8, 32'h00000000);
      @(posedge clk);
      #1;
      chk("stamp_stop", run, 32'h00000000);
      mode <= PDC_MODE_6B;
      frame(16'h0014, 32'h00002000, 16'h0000);
      chk("run6", run, 32'h00000001);
      @(posedge clk);
      #1;
      chk("trq_start", trq, 32'h000000C8);
      chk("accel", acc, 32'h00000064);
      chk("decel", dec, 32'h00000064);
      frame(16'h0014, 32'h00003000, 16'h0000);
      chk("retarget", {tgt[15:0], spd}, 32'h30000032);
      repeat (1000) @(posedge clk);
      chk("trq_travel", trq, 32'h00000096);
      frame(16'h0011, 32'h0, 16'h0000);
      chk("slow", {man, 15'h0, spd}, 32'h80000014);
      repeat (205) @(posedge clk);
      frame(16'h0010, 32'h0, 16'h0000);
      chk("man_end", run, 32'h00000000);
      frame(16'h0012, 32'h0, 16'h0000);
      chk("man_cw", {man, cw}, 32'h00000003);
      frame(16'h0000, 32'h0, 16'h0000);
      chk("man_cancel", run, 32'h00000000);
      frame(16'h0011, 32'h0, 16'h0000);
      chk("man_ccw", {man, cw}, 32'h00000002);
      frame(16'h0014, 32'h00004000, 16'h0000);
      chk("man_to_pos", {run, man}, 32'h00000002);
      frame(16'h0000, 32'h0, 16'h0000);
      frame(16'h0004, 32'h00005000, 16'h0000);
      chk("pending", run, 32'h00000000);
      frame(16'h0010, 32'h0, 16'h0000);
      chk("released", {run, tgt[30:0]}, 32'h80005000);
      frame(16'h0054, 32'h00006000, 16'h0000);
      chk("no_loop", loop, 32'h00000000);
      mode <= PDC_MODE_8B;
      frame(16'h0014, 32'h00007000, 16'h001E);
      chk("spd8", spd, 32'h0000001E);
      frame(16'h0014, 32'h00007000, 16'h0028);
      chk("spd_new", spd, 32'h00000028);
      frame(16'h0014, 32'h00007000, 16'h0000);
      chk("spd_zero", spd, 32'h00000032);
      apb(1'b1, 12'h240, 32'h00000014);
      frame(16'h0014, 32'h00007000, 16'h0028);
      chk("clamp_cw", spd, 32'h00000014);
      // eight steps short of the target: deceleration at one eighth
      ap <= 32'h00006FF8;
      @(posedge clk);
      #1;
      chk("decel_near", dec, 32'h0000000C);
      frame(16'h0014, 32'h00006000, 16'h0028);
      chk("reverse", {run, 15'h0, spd}, 32'h80000000);
      frame(16'h0014, 32'h00007000, 16'h0005);
      chk("bad_spd", {run, err}, 32'h00000001);
      apb(1'b0, 12'h320, 32'h0);
      chk("status_err", rd[12], 32'h00000001);
      frame(16'h4000, 32'h0, 16'h0000);
      chk("err_clear", err, 32'h00000000);
      stop_test();
   end
endmodule
`default_nettype wire
